/* File: core/dtgc_pkg.sv */
package dtgc_pkg;
  localparam int          CLK_HZ          = 250_000_000;
  localparam int          BURST_MS        = 51;
  localparam int          BURST_CYC       = CLK_HZ / 1000 * BURST_MS;
  localparam int          CNT_W           = 26;
  localparam int          SEG_NUM         = 32;
  localparam int          DIV_W           = 16;
  localparam int          CRA_TONE_OUTPUT_ENABLE_BIT    = 0;
  localparam int          CRA_MODE_BIT    = 1;
  localparam int          CRA_IRQ_BIT     = 2;
  localparam int          CRA_REDIR_BIT   = 3;
  localparam int          CRB_BURST_BIT   = 0;
  localparam int          CRB_TEST_BIT    = 1;
  localparam int          CRB_SINGLE_BIT  = 2;
  localparam int          CRB_COL_BIT     = 3;
  localparam int          ST_IRQ_BIT      = 0;
  localparam int          ST_TXRDY_BIT    = 1;
  localparam int          ST_RXFULL_BIT   = 2;
  localparam int          ST_DSTEER_BIT   = 3;
  localparam logic [3:0]  CRA_RESET       = 4'h0;
  localparam logic [3:0]  CRB_RESET       = 4'h0;
  localparam logic [3:0]  CODE_RESET      = 4'h0;
  // segment lengths in clk cycles; arbitrary short values, each row and column distinct
  localparam logic [15:0] ROW_DIV [4]     = '{16'h015E, 16'h013D, 16'h011F, 16'h0103};
  localparam logic [15:0] COL_DIV [4]     = '{16'h00CA, 16'h00B7, 16'h00A5, 16'h0095};

  typedef enum logic [2:0] {
    DTGC_IDLE  = 3'b001,
    DTGC_BURST = 3'b010,
    DTGC_PAUSE = 3'b100
  } dtgc_state_t;
endpackage : dtgc_pkg

/* File: core/dtgc_tone_path.sv */
`timescale 1ns/100ps
module dtgc_tone_path (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        run,
  input  wire logic [15:0] seg_len,
  output logic      [4:0]  phase,
  output logic      [7:0]  sample
);
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic [4:0]  next_phase;
  logic [7:0]  next_sample;

  function automatic logic [7:0] dtgc_sine(input logic [4:0] idx);
    logic [7:0] q;
    logic [2:0] k;
    q = 8'h00;
    k = idx[3] ? 3'(~idx[2:0]) : idx[2:0];
    case (k)
      3'd0: q = 8'h00;
      3'd1: q = 8'h19;
      3'd2: q = 8'h31;
      3'd3: q = 8'h47;
      3'd4: q = 8'h5A;
      3'd5: q = 8'h6A;
      3'd6: q = 8'h76;
      default: q = 8'h7D;
    endcase
    if (idx[3] && idx[2:0] == 3'd0) q = 8'h7F;
    return idx[4] ? 8'(8'h80 - q) : 8'(8'h80 + q);
  endfunction : dtgc_sine

  always_comb begin
    next_div_cnt = div_cnt;
    next_phase   = phase;
    if (!run) begin
      next_div_cnt = 16'h0000;
      next_phase   = 5'h00;
    end else if (div_cnt >= 16'(seg_len - 16'h0001)) begin
      next_div_cnt = 16'h0000;
      next_phase   = 5'(phase + 5'h01);
    end else begin
      next_div_cnt = 16'(div_cnt + 16'h0001);
    end
    next_sample = run ? dtgc_sine(next_phase) : 8'h80;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt <= 16'h0000;
      phase   <= 5'h00;
      sample  <= 8'h80;
    end else begin
      div_cnt <= next_div_cnt;
      phase   <= next_phase;
      sample  <= next_sample;
    end
  end

  chk_phase_wrap: assert property (@(posedge clk) disable iff (srst)
    run && $past(run) && div_cnt == 16'h0000 && $past(div_cnt) != 16'h0000
      |-> phase == 5'($past(phase) + 5'h01)) else $error("phase did not step on reload");
endmodule : dtgc_tone_path

/* File: core/dtgc_top.sv */
`timescale 1ns/100ps
module dtgc_top (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       register_select_line,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  input  wire logic       rx_valid,
  input  wire logic [3:0] rx_code,
  input  wire logic       rx_steer,
  input  wire logic       progress_limited_in,
  output logic            irq_progress_pin_out,
  output logic            irq_progress_pin_oe,
  output logic            tone_active,
  output logic      [7:0] row_sample,
  output logic      [7:0] col_sample
);
  localparam int               CNT_W     = dtgc_pkg::CNT_W;
  localparam logic [CNT_W-1:0] BURST_LEN = CNT_W'(dtgc_pkg::BURST_CYC);

  logic [3:0]  transceiver_control_a;
  logic [3:0]  transceiver_control_b;
  logic [3:0]  tx_code;
  logic [3:0]  rx_data;
  logic        rx_full;
  logic        tx_ready;
  logic        second_control_redirect;
  logic        wr_q;
  logic        rd_q;
  logic [3:0]  next_cra;
  logic [3:0]  next_crb;
  logic [3:0]  next_tx_code;
  logic [3:0]  next_rx_data;
  logic        next_rx_full;
  logic        next_tx_ready;
  logic        next_redirect;
  logic        wr_edge;
  logic        rd_edge;
  logic        code_wr;
  logic        ctrl_wr;
  logic        rx_rd;
  logic        st_rd;
  logic        tone_output_enable;
  logic        progress_mode_select;
  logic        irq_en;
  logic        burst_mode;
  logic        single_tone;
  logic        col_only;

  dtgc_pkg::dtgc_state_t state;
  dtgc_pkg::dtgc_state_t next_state;
  logic [CNT_W:0]  burst_cnt;
  logic [CNT_W:0]  next_burst_cnt;
  logic [CNT_W:0]  term_cnt;
  logic [7:0]      two_of_eight;
  logic [15:0]     row_len;
  logic [15:0]     col_len;
  logic            gen_on;
  logic            row_run;
  logic            col_run;
  logic [7:0]      row_raw;
  logic [7:0]      col_raw;
  logic            irq_level;
  logic            next_data_oe;
  logic [3:0]      next_data_out;
  logic [7:0]      next_row_sample;
  logic [7:0]      next_col_sample;
  logic            next_pin_oe;

  function automatic logic [7:0] dtgc_decode(input logic [3:0] code);
    logic [1:0] r;
    logic [1:0] c;
    r = 2'd0;
    c = 2'd0;
    case (code)
      4'h1: begin r = 2'd0; c = 2'd0; end
      4'h2: begin r = 2'd0; c = 2'd1; end
      4'h3: begin r = 2'd0; c = 2'd2; end
      4'h4: begin r = 2'd1; c = 2'd0; end
      4'h5: begin r = 2'd1; c = 2'd1; end
      4'h6: begin r = 2'd1; c = 2'd2; end
      4'h7: begin r = 2'd2; c = 2'd0; end
      4'h8: begin r = 2'd2; c = 2'd1; end
      4'h9: begin r = 2'd2; c = 2'd2; end
      4'hA: begin r = 2'd3; c = 2'd1; end
      4'hB: begin r = 2'd3; c = 2'd0; end
      4'hC: begin r = 2'd3; c = 2'd2; end
      4'hD: begin r = 2'd0; c = 2'd3; end
      4'hE: begin r = 2'd1; c = 2'd3; end
      4'hF: begin r = 2'd2; c = 2'd3; end
      default: begin r = 2'd3; c = 2'd3; end
    endcase
    return {4'(4'h1 << c), 4'(4'h1 << r)};
  endfunction : dtgc_decode

  function automatic logic [1:0] dtgc_index(input logic [3:0] hot);
    logic [1:0] i;
    i = 2'd0;
    case (hot)
      4'h2: i = 2'd1;
      4'h4: i = 2'd2;
      4'h8: i = 2'd3;
      default: i = 2'd0;
    endcase
    return i;
  endfunction : dtgc_index

  // bus decode
  assign tone_output_enable   = transceiver_control_a[dtgc_pkg::CRA_TONE_OUTPUT_ENABLE_BIT];
  assign progress_mode_select = transceiver_control_a[dtgc_pkg::CRA_MODE_BIT];
  assign irq_en               = transceiver_control_a[dtgc_pkg::CRA_IRQ_BIT];
  assign burst_mode           = !transceiver_control_b[dtgc_pkg::CRB_BURST_BIT];
  assign single_tone          = transceiver_control_b[dtgc_pkg::CRB_SINGLE_BIT];
  assign col_only             = transceiver_control_b[dtgc_pkg::CRB_COL_BIT];
  assign wr_edge = !cs_n && !wr_n && rd_n && !wr_q;
  assign rd_edge = !cs_n && !rd_n && wr_n && !rd_q;
  assign code_wr = wr_edge && !register_select_line;
  assign ctrl_wr = wr_edge && register_select_line;
  assign rx_rd   = rd_edge && !register_select_line;
  assign st_rd   = rd_edge && register_select_line;

  always_comb begin
    next_cra      = transceiver_control_a;
    next_crb      = transceiver_control_b;
    next_redirect = second_control_redirect;
    next_tx_code  = tx_code;
    next_rx_data  = rx_data;
    next_rx_full  = rx_full;
    if (ctrl_wr) begin
      if (second_control_redirect) begin
        next_crb      = data_in;
        next_redirect = 1'b0;
      end else begin
        next_cra      = data_in;
        next_redirect = data_in[dtgc_pkg::CRA_REDIR_BIT];
      end
    end
    if (code_wr) next_tx_code = data_in;
    if (st_rd || rx_rd) next_rx_full = 1'b0;
    if (rx_valid && !progress_mode_select) begin
      next_rx_data = rx_code;
      next_rx_full = 1'b1;
    end
  end

  // burst timer
  assign term_cnt = progress_mode_select ? {BURST_LEN, 1'b0} : {1'b0, BURST_LEN};
  always_comb begin
    next_state     = state;
    next_burst_cnt = burst_cnt;
    next_tx_ready  = tx_ready;
    if (st_rd) next_tx_ready = 1'b0;
    case (state)
      dtgc_pkg::DTGC_IDLE: begin
        next_burst_cnt = '0;
        if (code_wr && burst_mode) next_state = dtgc_pkg::DTGC_BURST;
      end
      dtgc_pkg::DTGC_BURST: begin
        next_burst_cnt = (CNT_W+1)'(burst_cnt + 1'b1);
        if (next_burst_cnt >= term_cnt) begin
          next_state     = dtgc_pkg::DTGC_PAUSE;
          next_burst_cnt = '0;
        end
      end
      dtgc_pkg::DTGC_PAUSE: begin
        next_burst_cnt = (CNT_W+1)'(burst_cnt + 1'b1);
        if (next_burst_cnt >= term_cnt) begin
          next_state    = dtgc_pkg::DTGC_IDLE;
          next_tx_ready = 1'b1;
        end
      end
      default: next_state = dtgc_pkg::DTGC_IDLE;
    endcase
    if (!burst_mode) begin
      next_state    = dtgc_pkg::DTGC_IDLE;
      next_tx_ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      transceiver_control_a   <= dtgc_pkg::CRA_RESET;
      transceiver_control_b   <= dtgc_pkg::CRB_RESET;
      second_control_redirect <= 1'b0;
      tx_code                 <= dtgc_pkg::CODE_RESET;
      rx_data                 <= 4'h0;
      rx_full                 <= 1'b0;
      tx_ready                <= 1'b0;
      state                   <= dtgc_pkg::DTGC_IDLE;
      burst_cnt               <= '0;
      wr_q                    <= 1'b0;
      rd_q                    <= 1'b0;
    end else begin
      transceiver_control_a   <= next_cra;
      transceiver_control_b   <= next_crb;
      second_control_redirect <= next_redirect;
      tx_code                 <= next_tx_code;
      rx_data                 <= next_rx_data;
      rx_full                 <= next_rx_full;
      tx_ready                <= next_tx_ready;
      state                   <= next_state;
      burst_cnt               <= next_burst_cnt;
      wr_q                    <= !cs_n && !wr_n;
      rd_q                    <= !cs_n && !rd_n;
    end
  end

  // generator
  assign two_of_eight = dtgc_decode(tx_code);
  assign row_len = dtgc_pkg::ROW_DIV[dtgc_index(two_of_eight[3:0])];
  assign col_len = dtgc_pkg::COL_DIV[dtgc_index(two_of_eight[7:4])];
  // generator gated by enable and burst phase, each tone also by the single tone bits; the time base clears to phase 0 whenever run is low
  assign gen_on  = tone_output_enable && (!burst_mode || state == dtgc_pkg::DTGC_BURST);
  assign row_run = gen_on && (!single_tone || !col_only);
  assign col_run = gen_on && (!single_tone || col_only);

  dtgc_tone_path u_row (
    .clk     (clk),
    .srst    (srst),
    .run     (row_run),
    .seg_len (row_len),
    .phase   (),
    .sample  (row_raw)
  );

  dtgc_tone_path u_col (
    .clk     (clk),
    .srst    (srst),
    .run     (col_run),
    .seg_len (col_len),
    .phase   (),
    .sample  (col_raw)
  );

  // pin and read data
  always_comb begin
    irq_level = 1'b0;
    if (progress_mode_select) begin
      irq_level = irq_en && !progress_limited_in;
    end else if (transceiver_control_b[dtgc_pkg::CRB_TEST_BIT]) begin
      irq_level = !rx_steer;
    end else begin
      irq_level = irq_en && (rx_full || tx_ready);
    end
    next_pin_oe     = irq_level;
    next_data_oe    = !cs_n && !rd_n && wr_n;
    next_data_out   = data_out;
    if (rd_edge) next_data_out = register_select_line ?
                                 {rx_steer, rx_full, tx_ready, rx_full || tx_ready} : rx_data;
    next_row_sample = row_raw;
    next_col_sample = col_raw;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_progress_pin_oe <= 1'b0;
      data_oe             <= 1'b0;
      data_out            <= 4'h0;
      row_sample          <= 8'h80;
      col_sample          <= 8'h80;
      tone_active         <= 1'b0;
    end else begin
      irq_progress_pin_oe <= next_pin_oe;
      data_oe             <= next_data_oe;
      data_out            <= next_data_out;
      row_sample          <= next_row_sample;
      col_sample          <= next_col_sample;
      tone_active         <= gen_on;
    end
  end
  assign irq_progress_pin_out = 1'b0;

  sequence s_burst_end;
    state == dtgc_pkg::DTGC_BURST ##1 state == dtgc_pkg::DTGC_PAUSE;
  endsequence

  sequence s_code_start;
    state == dtgc_pkg::DTGC_IDLE && code_wr && burst_mode;
  endsequence

  sequence s_pause_end;
    state == dtgc_pkg::DTGC_PAUSE && next_state == dtgc_pkg::DTGC_IDLE && burst_mode;
  endsequence

  sequence s_row_only;
    single_tone && !col_only ##1 single_tone && !col_only;
  endsequence

  sequence s_col_only;
    single_tone && col_only ##1 single_tone && col_only;
  endsequence

  chk_redirect_once: assert property (@(posedge clk) disable iff (srst)
    ctrl_wr && second_control_redirect |=> !second_control_redirect && transceiver_control_b == $past(data_in))
    else $error("redirected write missed control b");
  chk_cra_write: assert property (@(posedge clk) disable iff (srst)
    ctrl_wr && !second_control_redirect |=> transceiver_control_a == $past(data_in))
    else $error("control a not written");
  chk_code_latch: assert property (@(posedge clk) disable iff (srst)
    code_wr |=> tx_code == $past(data_in)) else $error("code not latched");
  chk_no_rx_cp: assert property (@(posedge clk) disable iff (srst)
    progress_mode_select && !rx_rd && !st_rd |=> rx_data == $past(rx_data) && rx_full == $past(rx_full))
    else $error("receive updated in progress mode");
  chk_ready_clear: assert property (@(posedge clk) disable iff (srst)
    !burst_mode |=> !tx_ready) else $error("ready set outside burst mode");
  chk_ready_set: assert property (@(posedge clk) disable iff (srst)
    s_pause_end |=> tx_ready)
    else $error("ready missed after pause");
  chk_burst_len: assert property (@(posedge clk) disable iff (srst)
    s_burst_end |-> $past(burst_cnt, 1) == (CNT_W+1)'(term_cnt - 1'b1))
    else $error("burst length wrong");
  chk_tone_gate: assert property (@(posedge clk) disable iff (srst)
    !tone_output_enable |=> !tone_active) else $error("tone without enable");
  chk_cp_pin: assert property (@(posedge clk) disable iff (srst)
    progress_mode_select && irq_en |=> irq_progress_pin_oe == !$past(progress_limited_in))
    else $error("progress pin wrong");
  chk_dt_irq: assert property (@(posedge clk) disable iff (srst)
    !progress_mode_select && !transceiver_control_b[dtgc_pkg::CRB_TEST_BIT] && irq_en && tx_ready
      |=> irq_progress_pin_oe) else $error("ready interrupt missing");
  chk_burst_start: assert property (@(posedge clk) disable iff (srst)
    s_code_start |=> state == dtgc_pkg::DTGC_BURST && burst_cnt == '0)
    else $error("burst did not start on code write");
  chk_term_dt: assert property (@(posedge clk) disable iff (srst)
    !progress_mode_select |-> term_cnt == (CNT_W+1)'(dtgc_pkg::BURST_CYC))
    else $error("single burst length wrong");
  chk_term_cp: assert property (@(posedge clk) disable iff (srst)
    progress_mode_select |-> term_cnt == (CNT_W+1)'(2 * dtgc_pkg::BURST_CYC))
    else $error("doubled burst length wrong");
  chk_burst_gap: assert property (@(posedge clk) disable iff (srst)
    burst_mode && state != dtgc_pkg::DTGC_BURST |=> !tone_active)
    else $error("tone outside burst");
  chk_rx_capture: assert property (@(posedge clk) disable iff (srst)
    rx_valid && !progress_mode_select |=> rx_full && rx_data == $past(rx_code))
    else $error("receive code lost in dual tone mode");
  chk_status_clear: assert property (@(posedge clk) disable iff (srst)
    st_rd && !(state == dtgc_pkg::DTGC_PAUSE && next_state == dtgc_pkg::DTGC_IDLE) |=> !tx_ready)
    else $error("ready not cleared by status read");
  chk_cp_quiet: assert property (@(posedge clk) disable iff (srst)
    progress_mode_select && !irq_en |=> !irq_progress_pin_oe)
    else $error("progress pin active without enable");
  chk_code_onehot: assert property (@(posedge clk) disable iff (srst)
    $onehot(two_of_eight[3:0]) && $onehot(two_of_eight[7:4]))
    else $error("code not two of eight");
  chk_row_single: assert property (@(posedge clk) disable iff (srst)
    s_row_only |=> col_sample == 8'h80) else $error("column tone in row only mode");
  chk_col_single: assert property (@(posedge clk) disable iff (srst)
    s_col_only |=> row_sample == 8'h80) else $error("row tone in column only mode");
  chk_data_hold: assert property (@(posedge clk) disable iff (srst)
    !rd_edge |=> data_out == $past(data_out)) else $error("read data changed during read");
endmodule : dtgc_top

/* File: verif/dtgc_host_model.sv */
`timescale 1ns/100ps
module dtgc_host_model (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            register_select_line,
  output logic      [3:0] data_in,
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    cs_n                 = 1'b1;
    rd_n                 = 1'b1;
    wr_n                 = 1'b1;
    register_select_line = 1'b0;
    data_in              = 4'hF;
  end

  // one write per strobe; select 0 is the code, 1 the control registers
  task automatic host_write(input logic sel, input logic [3:0] val);
    @(negedge clk);
    cs_n                 = 1'b0;
    wr_n                 = 1'b0;
    register_select_line = sel;
    data_in              = val;
    @(posedge clk);
    @(negedge clk);
    cs_n                 = 1'b1;
    wr_n                 = 1'b1;
    data_in              = ~val;
    @(negedge clk);
  endtask : host_write

  // select 0 reads the received code, 1 the status
  task automatic host_read(input logic sel, output logic [3:0] val, output logic oe);
    @(negedge clk);
    cs_n                 = 1'b0;
    rd_n                 = 1'b0;
    register_select_line = sel;
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    val                  = data_out;
    oe                   = data_oe;
    cs_n                 = 1'b1;
    rd_n                 = 1'b1;
    @(negedge clk);
  endtask : host_read
endmodule : dtgc_host_model

/* File: verif/dtgc_top_tb_top.sv */
`timescale 1ns/100ps
module dtgc_top_tb_top;
  logic       clk;
  logic       srst;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       register_select_line;
  logic [3:0] data_in;
  logic [3:0] data_out;
  logic       data_oe;
  logic       rx_valid;
  logic [3:0] rx_code;
  logic       rx_steer;
  logic       progress_limited_in;
  logic       irq_progress_pin_out;
  logic       irq_progress_pin_oe;
  logic       tone_active;
  logic [7:0] row_sample;
  logic [7:0] col_sample;
  int         n_fail;
  int         samples_checked;
  logic [3:0] rd_val;
  logic       rd_oe;
  logic       o0;
  logic       o1;
  logic       rch;
  logic       cch;

  dtgc_top u_dtgc_top (
    .clk(clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_select_line(register_select_line), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .rx_valid(rx_valid), .rx_code(rx_code), .rx_steer(rx_steer),
    .progress_limited_in(progress_limited_in), .irq_progress_pin_out(irq_progress_pin_out),
    .irq_progress_pin_oe(irq_progress_pin_oe), .tone_active(tone_active),
    .row_sample(row_sample), .col_sample(col_sample)
  );

  dtgc_host_model u_dtgc_host_model (
    .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_select_line(register_select_line), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : check

  task automatic rx_pulse(input logic [3:0] c);
    @(negedge clk);
    rx_code  = c;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
  endtask : rx_pulse

  task automatic status_is(input logic [3:0] exp);
    u_dtgc_host_model.host_read(1'b1, rd_val, rd_oe);
    check("status", {4'h0, exp}, {4'h0, rd_val});
    check("read enable", 8'h01, {7'h00, rd_oe});
  endtask : status_is

  // notes whether each sample leaves the value it had at the start
  task automatic watch_tone(input int n, output logic r, output logic c);
    logic [7:0] r0;
    logic [7:0] c0;
    r0 = row_sample;
    c0 = col_sample;
    r  = 1'b0;
    c  = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (row_sample !== r0) r = 1'b1;
      if (col_sample !== c0) c = 1'b1;
    end
  endtask : watch_tone

  task automatic level_oe(input logic lvl, output logic o);
    @(negedge clk);
    progress_limited_in = lvl;
    repeat (6) @(negedge clk);
    o = irq_progress_pin_oe;
  endtask : level_oe

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail              = 0;
    samples_checked     = 0;
    srst                = 1'b1;
    rx_valid            = 1'b0;
    rx_code             = 4'h0;
    rx_steer            = 1'b1;
    progress_limited_in = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    status_is(4'h8);
    // dual tone mode out of reset: receive is accepted
    rx_pulse(4'h7);
    status_is(4'hD);
    rx_pulse(4'h7);
    u_dtgc_host_model.host_write(1'b1, 4'h4);
    rx_pulse(4'h7);
    repeat (3) @(negedge clk);
    check("irq pull", 8'h01, {7'h00, irq_progress_pin_oe});
    check("irq pin level", 8'h00, {7'h00, irq_progress_pin_out});
    u_dtgc_host_model.host_read(1'b0, rd_val, rd_oe);
    check("rx code", 8'h07, {4'h0, rd_val});
    status_is(4'h8);
    status_is(4'h8);
    check("irq release", 8'h00, {7'h00, irq_progress_pin_oe});
    // progress mode with interrupt enable
    u_dtgc_host_model.host_write(1'b1, 4'h6);
    rx_pulse(4'h3);
    level_oe(1'b0, o0);
    level_oe(1'b1, o1);
    check("progress wave", 8'h01, {7'h00, o0 ^ o1});
    level_oe(1'b0, o0);
    check("progress wave back", 8'h01, {7'h00, o0 ^ o1});
    status_is(4'h8);
    u_dtgc_host_model.host_write(1'b1, 4'h2);
    level_oe(1'b0, o0);
    level_oe(1'b1, o1);
    check("no wave w/o enable", 8'h00, {6'h00, o0, o1});
    // every code in burst mode with output enabled
    u_dtgc_host_model.host_write(1'b1, 4'h9);
    u_dtgc_host_model.host_write(1'b1, 4'h0);
    for (int k = 0; k < 16; k++) begin
      u_dtgc_host_model.host_write(1'b0, k[3:0]);
      watch_tone(1200, rch, cch);
      check("burst running", 8'h01, {7'h00, tone_active});
      check("row and col step", 8'h03, {6'h00, rch, cch});
    end
    u_dtgc_host_model.host_write(1'b1, 4'h0);
    repeat (10) @(negedge clk);
    check("gated row", 8'h80, row_sample);
    check("gated col", 8'h80, col_sample);
    // control B: burst off, single row tone
    u_dtgc_host_model.host_write(1'b1, 4'h9);
    u_dtgc_host_model.host_write(1'b1, 4'h5);
    u_dtgc_host_model.host_write(1'b1, 4'h1);
    u_dtgc_host_model.host_write(1'b0, 4'h5);
    watch_tone(1200, rch, cch);
    check("single row", 8'h02, {6'h00, rch, cch});
    check("row only col idle", 8'h80, col_sample);
    status_is(4'h8);
    // single column tone
    u_dtgc_host_model.host_write(1'b1, 4'h9);
    u_dtgc_host_model.host_write(1'b1, 4'hD);
    u_dtgc_host_model.host_write(1'b1, 4'h1);
    repeat (10) @(negedge clk);
    watch_tone(1200, rch, cch);
    check("single col", 8'h01, {6'h00, rch, cch});
    check("col only row idle", 8'h80, row_sample);
    u_dtgc_host_model.host_write(1'b1, 4'h0);
    repeat (10) @(negedge clk);
    check("host gated col", 8'h80, col_sample);
    // test bit routes inverted steering to the pin
    u_dtgc_host_model.host_write(1'b1, 4'h8);
    u_dtgc_host_model.host_write(1'b1, 4'h2);
    @(negedge clk);
    rx_steer = 1'b0;
    repeat (3) @(negedge clk);
    check("steer on pin", 8'h01, {7'h00, irq_progress_pin_oe});
    rx_steer = 1'b1;
    repeat (3) @(negedge clk);
    check("steer off pin", 8'h00, {7'h00, irq_progress_pin_oe});
    complete_run();
  end
endmodule : dtgc_top_tb_top
